//--- ebls_host_model.sv
// Host side model driving the link pins of the byte lane swap block
`default_nettype none
module ebls_host_model
    import ebls_pkg::*;
(
    input  wire logic              core_clk,
    output var  logic              pci_clk,
    output var  logic              pci_req,
    output var  logic              pci_we,
    output var  logic              pci_mmio_sel,
    output var  logic [DATA_W-1:0] pci_addr,
    output var  logic [DATA_W-1:0] pci_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {pci_clk, pci_req, pci_we, pci_mmio_sel} = 4'h0;
        {pci_addr, pci_wdata} = '0;
    end
    // One access per link clock rise; the clock stands still between frames
    task automatic access(input logic we, sel, input logic [DATA_W-1:0] a, d);
        @(posedge core_clk);
        {pci_req, pci_we, pci_mmio_sel} <= {1'b1, we, sel};
        pci_addr  <= a;
        pci_wdata <= d;
        repeat (4) @(posedge core_clk);
        pci_clk <= 1'b1;
        repeat (4) @(posedge core_clk);
        pci_clk <= 1'b0;
        repeat (4) @(posedge core_clk);
        // Released lines show the inverse so stale data cannot pass for valid
        pci_req   <= 1'b0;
        pci_addr  <= ~a;
        pci_wdata <= ~d;
    endtask
endmodule
`default_nettype wire

//--- ebls_lane_map.sv
// Maps a core register value onto bus lanes and bus lanes back to a register value
`default_nettype none
module ebls_lane_map
    import ebls_pkg::*;
(
    input  wire logic              big,
    input  wire ebls_size_t        size,
    input  wire logic [OFF_W-1:0]  off,
    input  wire logic [DATA_W-1:0] reg_in,
    input  wire logic [DATA_W-1:0] lane_in,
    output logic      [DATA_W-1:0] lanes_out,
    output logic      [DATA_W-1:0] reg_out,
    output logic      [LANES-1:0]  be
);
    logic [HALF_W-1:0] h_wr;
    logic [HALF_W-1:0] h_rd;

    always_comb begin
        lanes_out = '0;
        reg_out   = '0;
        be        = BE_NONE;
        h_wr      = big ? ebls_hswap(reg_in[HALF_W-1:0]) : reg_in[HALF_W-1:0];
        h_rd      = off[1] ? lane_in[DATA_W-1:HALF_W] : lane_in[HALF_W-1:0];
        unique case (size)
            EBLS_SZ_WORD: begin
                lanes_out = big ? ebls_bswap(reg_in) : reg_in;
                reg_out   = big ? ebls_bswap(lane_in) : lane_in;
                be        = BE_ALL;
            end
            EBLS_SZ_HALF: begin
                if (off[1]) begin
                    lanes_out = {h_wr, {HALF_W{1'b0}}};
                    be        = BE_HIGH_HALF;
                end else begin
                    lanes_out = {{HALF_W{1'b0}}, h_wr};
                    be        = BE_LOW_HALF;
                end
                reg_out = {{HALF_W{1'b0}}, big ? ebls_hswap(h_rd) : h_rd};
            end
            EBLS_SZ_BYTE: begin
                for (int i = 0; i < LANES; i++) begin
                    if (off == OFF_W'(i)) begin
                        lanes_out[i*BYTE_W +: BYTE_W] = reg_in[BYTE_W-1:0];
                        be[i] = 1'b1;
                    end
                end
                reg_out = {{(DATA_W-BYTE_W){1'b0}}, lane_in[{off, 3'h0} +: BYTE_W]};
            end
            default: begin
                lanes_out = '0;
            end
        endcase
    end
endmodule
`default_nettype wire

//--- ebls_pkg.sv
// Shared constants, types and byte-order helpers for the byte lane swap block
`default_nettype none
package ebls_pkg;
    localparam int unsigned DATA_W  = 32;
    localparam int unsigned BYTE_W  = 8;
    localparam int unsigned HALF_W  = 16;
    localparam int unsigned LANES   = 4;
    localparam int unsigned OFF_W   = 2;

    localparam logic [LANES-1:0] BE_ALL       = 4'hf;
    localparam logic [LANES-1:0] BE_LOW_HALF  = 4'h3;
    localparam logic [LANES-1:0] BE_HIGH_HALF = 4'hc;
    localparam logic [LANES-1:0] BE_NONE      = 4'h0;

    localparam logic ORDER_LITTLE  = 1'b1;
    localparam logic SWAP_EN_RESET = 1'b0;
    localparam int unsigned SWAP_EN_POS = 0;

    typedef enum logic [1:0] {
        EBLS_SZ_BYTE,
        EBLS_SZ_HALF,
        EBLS_SZ_WORD
    } ebls_size_t;

    typedef enum logic {
        EBLS_IDLE,
        EBLS_WAIT
    } ebls_st_t;

    // Reverse the four bytes of a word, bits inside each byte untouched
    function automatic logic [DATA_W-1:0] ebls_bswap(input logic [DATA_W-1:0] w);
        logic [DATA_W-1:0] r;
        r = '0;
        for (int i = 0; i < LANES; i++) begin
            r[i*BYTE_W +: BYTE_W] = w[(LANES-1-i)*BYTE_W +: BYTE_W];
        end
        return r;
    endfunction

    // Swap the two bytes of a halfword
    function automatic logic [HALF_W-1:0] ebls_hswap(input logic [HALF_W-1:0] h);
        return {h[BYTE_W-1:0], h[HALF_W-1:BYTE_W]};
    endfunction
endpackage
`default_nettype wire

//--- ebls_top.sv
// Data cache load/store lane translation and host bridge register swapper
// Notes on behaviour
// - Four byte lanes: lane3 31:24, lane2 23:16, lane1 15:8, lane0 7:0.
// - Byte at address offset n always travels on lane n.
// - Core byte-order bit: 1 little endian, 0 big endian; steers cache loads/stores.
// - Big endian: word reversed, halfword swapped onto its half, byte on its lane.
// - Load/store translation only inside memory window base to limit-1, and at the transfer register.
// - Core register-space accesses pass without byte reordering.
// - Core accesses to the bridge transfer register are translated like memory.
// - Instruction fetch is always little endian, ignoring the byte-order bit.
// - Host memory data through the bridge is never reordered.
// - Swap flag 0 reverses host register accesses; 1 swaps none.
// - Swap flag resets to 0, so the write setting it is reversed.
// - The bridge has no special case for the transfer register; host register accesses to it follow the swap flag.
// - Host word 0x04050607 (little) or 0x07060504 (big) word-loads as 0x04050607; byte load 0x04 big, 0x07 little.
// - Little endian: register bytes placed on lanes without reordering.
// - Swaps move whole bytes only; bit order within bytes untouched.
`default_nettype none
module ebls_top
    import ebls_pkg::*;
#(
    parameter logic [DATA_W-1:0] BRIDGE_CTL_ADDR = 32'h0000_0100,
    parameter logic [DATA_W-1:0] XFER_DATA_ADDR  = 32'h0000_0104
)(
    input  wire logic              core_clk,
    input  wire logic              reset,
    input  wire logic              core_byte_order_bit,
    input  wire logic [DATA_W-1:0] mem_base,
    input  wire logic [DATA_W-1:0] mem_limit,
    input  wire logic              dc_req,
    input  wire logic              dc_we,
    input  wire ebls_size_t        dc_size,
    input  wire logic [DATA_W-1:0] dc_addr,
    input  wire logic [DATA_W-1:0] dc_wdata,
    input  wire logic              dc_mmio,
    output logic                   dc_ready,
    output logic      [DATA_W-1:0] dc_rdata,
    output logic                   dc_rvalid,
    output logic                   hwy_req,
    output logic                   hwy_we,
    output logic      [DATA_W-1:0] hwy_addr,
    output logic      [LANES-1:0]  hwy_be,
    output logic      [DATA_W-1:0] hwy_wdata,
    input  wire logic              hwy_rvalid,
    input  wire logic [DATA_W-1:0] hwy_rdata,
    input  wire logic              ic_valid,
    input  wire logic [DATA_W-1:0] ic_lane_data,
    output logic                   ic_word_valid,
    output logic      [DATA_W-1:0] ic_word,
    input  wire logic              pci_clk,
    input  wire logic              pci_req,
    input  wire logic              pci_we,
    input  wire logic              pci_mmio_sel,
    input  wire logic [DATA_W-1:0] pci_addr,
    input  wire logic [DATA_W-1:0] pci_wdata,
    output logic                   pci_rvalid,
    output logic      [DATA_W-1:0] pci_rdata,
    output logic                   bridge_swap_enable,
    output logic                   mmio_req,
    output logic                   mmio_we,
    output logic      [DATA_W-1:0] mmio_addr,
    output logic      [DATA_W-1:0] mmio_wdata,
    input  wire logic              mmio_rvalid,
    input  wire logic [DATA_W-1:0] mmio_rdata,
    output logic                   mem_req,
    output logic                   mem_we,
    output logic      [DATA_W-1:0] mem_addr,
    output logic      [DATA_W-1:0] mem_wdata,
    input  wire logic              mem_rvalid,
    input  wire logic [DATA_W-1:0] mem_rdata
);
    typedef struct packed {
        logic              pci_clk_s1;
        logic              pci_clk_s2;
        logic              pci_clk_s3;
        logic              pci_req_s1;
        logic              pci_req_s2;
        logic              pci_we_s1;
        logic              pci_we_s2;
        logic              pci_sel_s1;
        logic              pci_sel_s2;
        logic [DATA_W-1:0] pci_addr_s1;
        logic [DATA_W-1:0] pci_addr_s2;
        logic [DATA_W-1:0] pci_wdata_s1;
        logic [DATA_W-1:0] pci_wdata_s2;
        logic              swap_en;
        ebls_st_t          pci_st;
        logic              pci_swap_lat;
        logic              pci_from_mmio;
        logic              pci_rvalid;
        logic [DATA_W-1:0] pci_rdata;
        logic              mmio_req;
        logic              mmio_we;
        logic [DATA_W-1:0] mmio_addr;
        logic [DATA_W-1:0] mmio_wdata;
        logic              mem_req;
        logic              mem_we;
        logic [DATA_W-1:0] mem_addr;
        logic [DATA_W-1:0] mem_wdata;
        ebls_st_t          dc_st;
        logic              dc_big_lat;
        ebls_size_t        dc_size_lat;
        logic [OFF_W-1:0]  dc_off_lat;
        logic              dc_rvalid;
        logic [DATA_W-1:0] dc_rdata;
        logic              hwy_req;
        logic              hwy_we;
        logic [DATA_W-1:0] hwy_addr;
        logic [LANES-1:0]  hwy_be;
        logic [DATA_W-1:0] hwy_wdata;
        logic              ic_valid;
        logic [DATA_W-1:0] ic_word;
    } ebls_state_t;

    ebls_state_t q;
    ebls_state_t d;

    logic              is_xfer;
    logic              in_window;
    logic              dc_translate;
    logic              dc_big;
    logic              dc_take;
    logic              pci_edge;
    logic              pci_take;
    logic              pci_swap_now;
    logic [DATA_W-1:0] pci_in_data;
    logic [DATA_W-1:0] ctl_val;
    logic [DATA_W-1:0] wr_lanes;
    logic [LANES-1:0]  wr_be;
    logic [DATA_W-1:0] rd_reg;

    assign is_xfer      = (dc_addr == XFER_DATA_ADDR);
    assign in_window    = (dc_addr >= mem_base) && (dc_addr < mem_limit);
    assign dc_translate = is_xfer || (!dc_mmio && in_window);
    assign dc_big       = dc_translate && (core_byte_order_bit != ORDER_LITTLE);
    assign dc_ready     = (q.dc_st == EBLS_IDLE);
    assign dc_take      = dc_req && dc_ready;
    assign pci_edge     = q.pci_clk_s2 && !q.pci_clk_s3;
    assign pci_take     = pci_edge && q.pci_req_s2 && (q.pci_st == EBLS_IDLE);
    assign pci_swap_now = (q.swap_en == SWAP_EN_RESET);
    assign pci_in_data  = pci_swap_now ? ebls_bswap(q.pci_wdata_s2) : q.pci_wdata_s2;

    always_comb begin
        ctl_val = '0;
        ctl_val[SWAP_EN_POS] = q.swap_en;
    end

    ebls_lane_map u_wr_map (
        .big       (dc_big),
        .size      (dc_size),
        .off       (dc_addr[OFF_W-1:0]),
        .reg_in    (dc_wdata),
        .lane_in   ('0),
        .lanes_out (wr_lanes),
        .reg_out   (),
        .be        (wr_be)
    );

    ebls_lane_map u_rd_map (
        .big       (q.dc_big_lat),
        .size      (q.dc_size_lat),
        .off       (q.dc_off_lat),
        .reg_in    ('0),
        .lane_in   (hwy_rdata),
        .lanes_out (),
        .reg_out   (rd_reg),
        .be        ()
    );

    always_comb begin
        d = q;
        // Two-flop synchronisers for the host pins
        d.pci_clk_s1   = pci_clk;
        d.pci_clk_s2   = q.pci_clk_s1;
        d.pci_clk_s3   = q.pci_clk_s2;
        d.pci_req_s1   = pci_req;
        d.pci_req_s2   = q.pci_req_s1;
        d.pci_we_s1    = pci_we;
        d.pci_we_s2    = q.pci_we_s1;
        d.pci_sel_s1   = pci_mmio_sel;
        d.pci_sel_s2   = q.pci_sel_s1;
        d.pci_addr_s1  = pci_addr;
        d.pci_addr_s2  = q.pci_addr_s1;
        d.pci_wdata_s1 = pci_wdata;
        d.pci_wdata_s2 = q.pci_wdata_s1;
        d.hwy_req   = 1'b0;
        d.mmio_req  = 1'b0;
        d.mem_req   = 1'b0;
        d.dc_rvalid = 1'b0;
        // Instruction words pass straight through
        d.ic_valid = ic_valid;
        if (ic_valid) begin
            d.ic_word = ic_lane_data;
        end
        // Core loads and stores
        unique case (q.dc_st)
            EBLS_IDLE: begin
                if (dc_take) begin
                    d.hwy_req     = 1'b1;
                    d.hwy_we      = dc_we;
                    d.hwy_addr    = dc_addr;
                    d.hwy_be      = wr_be;
                    d.hwy_wdata   = dc_we ? wr_lanes : '0;
                    d.dc_big_lat  = dc_big;
                    d.dc_size_lat = dc_size;
                    d.dc_off_lat  = dc_addr[OFF_W-1:0];
                    if (!dc_we) begin
                        d.dc_st = EBLS_WAIT;
                    end
                end
            end
            EBLS_WAIT: begin
                if (hwy_rvalid) begin
                    d.dc_rdata  = rd_reg;
                    d.dc_rvalid = 1'b1;
                    d.dc_st     = EBLS_IDLE;
                end
            end
        endcase
        // Host side accesses, taken on a host clock rising edge
        unique case (q.pci_st)
            EBLS_IDLE: begin
                if (pci_take) begin
                    d.pci_rvalid = 1'b0;
                    if (q.pci_sel_s2 && q.pci_addr_s2 == BRIDGE_CTL_ADDR) begin
                        if (q.pci_we_s2) begin
                            d.swap_en = pci_in_data[SWAP_EN_POS];
                        end else begin
                            d.pci_rdata  = pci_swap_now ? ebls_bswap(ctl_val) : ctl_val;
                            d.pci_rvalid = 1'b1;
                        end
                    end else if (q.pci_sel_s2) begin
                        d.mmio_req   = 1'b1;
                        d.mmio_we    = q.pci_we_s2;
                        d.mmio_addr  = q.pci_addr_s2;
                        d.mmio_wdata = q.pci_we_s2 ? pci_in_data : '0;
                    end else begin
                        d.mem_req   = 1'b1;
                        d.mem_we    = q.pci_we_s2;
                        d.mem_addr  = q.pci_addr_s2;
                        d.mem_wdata = q.pci_we_s2 ? q.pci_wdata_s2 : '0;
                    end
                    if (!q.pci_we_s2 && q.pci_addr_s2 != BRIDGE_CTL_ADDR
                        || !q.pci_we_s2 && !q.pci_sel_s2) begin
                        d.pci_st        = EBLS_WAIT;
                        d.pci_swap_lat  = pci_swap_now;
                        d.pci_from_mmio = q.pci_sel_s2;
                    end
                end
            end
            EBLS_WAIT: begin
                if (q.pci_from_mmio && mmio_rvalid) begin
                    d.pci_rdata  = q.pci_swap_lat ? ebls_bswap(mmio_rdata) : mmio_rdata;
                    d.pci_rvalid = 1'b1;
                    d.pci_st     = EBLS_IDLE;
                end else if (!q.pci_from_mmio && mem_rvalid) begin
                    d.pci_rdata  = mem_rdata;
                    d.pci_rvalid = 1'b1;
                    d.pci_st     = EBLS_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            q         <= '0;
            q.swap_en <= SWAP_EN_RESET;
            q.pci_st  <= EBLS_IDLE;
            q.dc_st   <= EBLS_IDLE;
        end else begin
            q <= d;
        end
    end

    assign dc_rdata           = q.dc_rdata;
    assign dc_rvalid          = q.dc_rvalid;
    assign hwy_req            = q.hwy_req;
    assign hwy_we             = q.hwy_we;
    assign hwy_addr           = q.hwy_addr;
    assign hwy_be             = q.hwy_be;
    assign hwy_wdata          = q.hwy_wdata;
    assign ic_word_valid      = q.ic_valid;
    assign ic_word            = q.ic_word;
    assign pci_rvalid         = q.pci_rvalid;
    assign pci_rdata          = q.pci_rdata;
    assign bridge_swap_enable = q.swap_en;
    assign mmio_req           = q.mmio_req;
    assign mmio_we            = q.mmio_we;
    assign mmio_addr          = q.mmio_addr;
    assign mmio_wdata         = q.mmio_wdata;
    assign mem_req            = q.mem_req;
    assign mem_we             = q.mem_we;
    assign mem_addr           = q.mem_addr;
    assign mem_wdata          = q.mem_wdata;

    // Checks
    logic [DATA_W-1:0] pci_wdata_sync;
    logic              swap_en_q;
    logic              dc_word_wr;
    assign pci_wdata_sync = q.pci_wdata_s2;
    assign swap_en_q      = q.swap_en;
    assign dc_word_wr     = dc_take && dc_we && dc_size == EBLS_SZ_WORD;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    chk_word_big: assert property (dc_word_wr && dc_big |=> hwy_wdata == ebls_bswap($past(dc_wdata)))
        else $error("big endian word store not reversed");
    chk_word_little: assert property (dc_word_wr && in_window && !dc_mmio
        && core_byte_order_bit == ORDER_LITTLE |=> hwy_wdata == $past(dc_wdata))
        else $error("little endian word store reordered");
    chk_mmio_plain: assert property (dc_word_wr && dc_mmio && !is_xfer
        |=> hwy_wdata == $past(dc_wdata))
        else $error("core register access reordered");
    chk_xfer_swap: assert property (dc_word_wr && is_xfer && core_byte_order_bit != ORDER_LITTLE
        |=> hwy_wdata == ebls_bswap($past(dc_wdata)))
        else $error("transfer register store not translated");
    chk_window_out: assert property (dc_word_wr && !is_xfer && !in_window
        |=> hwy_wdata == $past(dc_wdata))
        else $error("store outside window translated");
    chk_byte_lane: assert property (dc_take && dc_size == EBLS_SZ_BYTE
        |=> hwy_be == (LANES'(1) << $past(dc_addr[OFF_W-1:0])))
        else $error("byte on wrong lane");
    chk_ifetch_pass: assert property (ic_valid |=> ic_word_valid && ic_word == $past(ic_lane_data))
        else $error("instruction word altered");
    chk_mem_plain: assert property (mem_req && mem_we |-> mem_wdata == $past(pci_wdata_sync))
        else $error("host memory data reordered");
    chk_mmio_swap: assert property (mmio_req && mmio_we |-> mmio_wdata == ($past(swap_en_q)
        ? $past(pci_wdata_sync) : ebls_bswap($past(pci_wdata_sync))))
        else $error("host register data swap wrong");
    chk_swap_reset: assert property (@(posedge core_clk) $fell(reset) |-> swap_en_q == SWAP_EN_RESET)
        else $error("swap flag not cleared by reset");
    chk_read_done: assert property (q.dc_st == EBLS_WAIT && hwy_rvalid
        |=> dc_rvalid && dc_ready)
        else $error("core load answer missing");

    cov_core_load: cover property (dc_take && !dc_we && dc_big ##[1:20] dc_rvalid);
    cov_swap_set: cover property ($rose(swap_en_q));
    cov_host_mem_rd: cover property (mem_req && !mem_we ##[1:40] pci_rvalid);
    cov_host_reg_rd: cover property (mmio_req && !mmio_we ##[1:40] pci_rvalid);
endmodule
`default_nettype wire

//--- ebls_top_tb.sv
// Self-checking bench for the byte lane swap block
`default_nettype none
module ebls_top_tb
    import ebls_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [DATA_W-1:0] CTL = 32'h0000_0100;
    localparam logic [DATA_W-1:0] XFR = 32'h0000_0104;
    localparam logic [DATA_W-1:0] WIN = 32'h0000_1000;
    localparam logic [DATA_W-1:0] PAT = 32'h8102_c304;
    logic core_clk = 1'b0;
    logic reset    = 1'b1;
    logic core_byte_order_bit, dc_req, dc_we, dc_mmio, hwy_rvalid, ic_valid, mmio_rvalid;
    logic mem_rvalid;
    ebls_size_t dc_size;
    logic [DATA_W-1:0] mem_base, mem_limit, dc_addr, dc_wdata, hwy_rdata, ic_lane_data;
    logic [DATA_W-1:0] mmio_rdata, mem_rdata, mm_wd, me_wd;
    wire logic dc_ready, dc_rvalid, hwy_req, hwy_we, ic_word_valid, pci_clk, pci_req, pci_we;
    wire logic pci_mmio_sel, pci_rvalid, bridge_swap_enable, mmio_req, mmio_we, mem_req, mem_we;
    wire logic [DATA_W-1:0] dc_rdata, hwy_wdata, ic_word, pci_addr, pci_wdata, pci_rdata;
    wire logic [DATA_W-1:0] mmio_wdata, mem_wdata, hwy_addr;
    wire logic [LANES-1:0]  hwy_be;
    int fail_count = 0;
    int n_checks   = 0;

    ebls_top #(.BRIDGE_CTL_ADDR(CTL), .XFER_DATA_ADDR(XFR)) uut (
        .core_clk, .reset, .core_byte_order_bit, .mem_base, .mem_limit, .dc_req, .dc_we,
        .dc_size, .dc_addr, .dc_wdata, .dc_mmio, .dc_ready, .dc_rdata, .dc_rvalid, .hwy_req,
        .hwy_we, .hwy_addr, .hwy_be, .hwy_wdata, .hwy_rvalid, .hwy_rdata, .ic_valid,
        .ic_lane_data, .ic_word_valid, .ic_word, .pci_clk, .pci_req, .pci_we, .pci_mmio_sel,
        .pci_addr, .pci_wdata, .pci_rvalid, .pci_rdata, .bridge_swap_enable, .mmio_req,
        .mmio_we, .mmio_addr(), .mmio_wdata, .mmio_rvalid, .mmio_rdata, .mem_req, .mem_we,
        .mem_addr(), .mem_wdata, .mem_rvalid, .mem_rdata);
    ebls_host_model host (.core_clk, .pci_clk, .pci_req, .pci_we, .pci_mmio_sel, .pci_addr,
        .pci_wdata);

    always #25 core_clk = ~core_clk;

    // Far-side responders answer each read one cycle after its request
    always @(posedge core_clk) begin
        hwy_rvalid  <= hwy_req === 1'b1 && hwy_we === 1'b0;
        mmio_rvalid <= mmio_req === 1'b1 && mmio_we === 1'b0;
        mem_rvalid  <= mem_req === 1'b1 && mem_we === 1'b0;
        if (mmio_req === 1'b1) mm_wd <= mmio_wdata;
        if (mem_req === 1'b1) me_wd <= mem_wdata;
    end

    task automatic check(input string what, input logic [DATA_W-1:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Expected byte enables and lanes of a store
    function automatic logic [35:0] elane(input logic big, input ebls_size_t sz,
                                          input logic [1:0] off, input logic [DATA_W-1:0] v);
        logic [15:0] h;
        h = big ? {v[7:0], v[15:8]} : v[15:0];
        case (sz)
            EBLS_SZ_WORD: return {4'hf, big ? {v[7:0], v[15:8], v[23:16], v[31:24]} : v};
            EBLS_SZ_HALF: return off[1] ? {4'hc, h, 16'h0} : {4'h3, 16'h0, h};
            default: return {4'h1 << off, 32'(v[7:0]) << (8 * off)};
        endcase
    endfunction

    // Core access; d is store data or the lanes returned to a load
    task automatic core_op(input logic big, we, mmio, flip, input ebls_size_t sz,
                           input logic [DATA_W-1:0] a, d, output logic [35:0] ln,
                           output logic [DATA_W-1:0] rd);
        int i;
        @(posedge core_clk);
        core_byte_order_bit <= ~big;
        {dc_req, dc_we, dc_mmio} <= {1'b1, we, mmio};
        dc_size   <= sz;
        dc_addr   <= a;
        dc_wdata  <= d;
        hwy_rdata <= d;
        @(posedge core_clk);
        dc_req <= 1'b0;
        if (flip) core_byte_order_bit <= big;
        #1;
        ln = {hwy_be, hwy_wdata & {{8{hwy_be[3]}}, {8{hwy_be[2]}}, {8{hwy_be[1]}}, {8{hwy_be[0]}}}};
        check("hwy_req", 32'(hwy_req), 32'h1);
        check("hwy_addr", hwy_addr, a);
        check("dc_ready", 32'(dc_ready), 32'(we));
        i = 0;
        while (!we && dc_rvalid !== 1'b1 && i < 20) begin
            @(posedge core_clk);
            #1;
            i++;
        end
        if (!we) begin
            check("load answer", 32'(dc_rvalid), 32'h1);
        end
        rd = dc_rdata;
    endtask

    task automatic host_rd(input logic sel, input logic [DATA_W-1:0] a, exp, input string what);
        int i;
        host.access(1'b0, sel, a, 32'h0);
        i = 0;
        while (pci_rvalid !== 1'b1 && i < 20) begin
            @(posedge core_clk);
            i++;
        end
        check("host answer", 32'(pci_rvalid), 32'h1);
        check(what, pci_rdata, exp);
    endtask

    task automatic t_bridge();
        check("swap after reset", 32'(bridge_swap_enable), 32'h0);
        host.access(1'b1, 1'b1, 32'h200, 32'h1122_3344);
        check("reg write swapped", mm_wd, 32'h4433_2211);
        host_rd(1'b1, 32'h200, 32'hd4c3_b2a1, "reg read swapped");
        host_rd(1'b0, WIN, PAT, "mem read");
        host.access(1'b1, 1'b1, CTL, 32'h0100_0000);
        check("swap set", 32'(bridge_swap_enable), 32'h1);
        host_rd(1'b1, CTL, 32'h0000_0001, "ctl read");
        host.access(1'b1, 1'b1, 32'h200, 32'h1122_3344);
        check("reg write plain", mm_wd, 32'h1122_3344);
        host_rd(1'b1, 32'h200, 32'ha1b2_c3d4, "reg read plain");
        @(posedge core_clk);
        reset <= 1'b1;
        @(posedge core_clk);
        reset <= 1'b0;
        #1;
        check("swap after mid reset", 32'(bridge_swap_enable), 32'h0);
        $display("test bridge done");
    endtask

    task automatic t_store();
        ebls_size_t sz;
        logic [1:0] off;
        logic [35:0] ln, e;
        logic [DATA_W-1:0] rd;
        for (int b = 0; b < 2; b++) begin
            for (int k = 0; k < 7; k++) begin
                sz  = k == 0 ? EBLS_SZ_WORD : (k < 3 ? EBLS_SZ_HALF : EBLS_SZ_BYTE);
                off = k == 0 ? 2'h0 : (k < 3 ? 2'(2 * (k - 1)) : 2'(k - 3));
                core_op(b[0], 1'b1, 1'b0, 1'b0, sz, WIN + 32'(off), PAT, ln, rd);
                e = elane(b[0], sz, off, PAT);
                check("store lanes", ln[31:0], e[31:0]);
                check("store enables", 32'(ln[35:32]), 32'(e[35:32]));
            end
        end
        $display("test store lanes done");
    endtask

    task automatic t_window();
        logic [35:0] ln;
        logic [DATA_W-1:0] rd;
        core_op(1'b1, 1'b1, 1'b0, 1'b0, EBLS_SZ_WORD, mem_limit, PAT, ln, rd);
        check("outside window", ln[31:0], PAT);
        core_op(1'b1, 1'b1, 1'b1, 1'b0, EBLS_SZ_WORD, WIN + 32'h10, PAT, ln, rd);
        check("register store", ln[31:0], PAT);
        core_op(1'b1, 1'b0, 1'b1, 1'b0, EBLS_SZ_WORD, WIN + 32'h10, PAT, ln, rd);
        check("register load", rd, PAT);
        core_op(1'b1, 1'b1, 1'b1, 1'b0, EBLS_SZ_WORD, XFR, PAT, ln, rd);
        check("transfer store", ln[31:0], 32'h04c3_0281);
        core_op(1'b0, 1'b1, 1'b1, 1'b0, EBLS_SZ_WORD, XFR, 32'h04c3_0281, ln, rd);
        check("pre-reversed transfer", ln[31:0], 32'h04c3_0281);
        $display("test window done");
    endtask

    task automatic t_roundtrip();
        logic [35:0] ln;
        logic [DATA_W-1:0] rd, img;
        for (int b = 0; b < 2; b++) begin
            img = b ? 32'h0706_0504 : 32'h0405_0607;
            host.access(1'b1, 1'b0, WIN, img);
            check("host mem write", me_wd, img);
            core_op(b[0], 1'b0, 1'b0, b[0], EBLS_SZ_WORD, WIN, img, ln, rd);
            check("word load", rd, 32'h0405_0607);
            core_op(b[0], 1'b0, 1'b0, 1'b0, EBLS_SZ_BYTE, WIN, img, ln, rd);
            check("byte load", rd, b ? 32'h04 : 32'h07);
        end
        $display("test round trip done");
    endtask

    task automatic t_ifetch();
        @(posedge core_clk);
        core_byte_order_bit <= 1'b0;
        ic_valid     <= 1'b1;
        ic_lane_data <= PAT;
        @(posedge core_clk);
        ic_valid <= 1'b0;
        #1;
        check("fetch valid", 32'(ic_word_valid), 32'h1);
        check("fetch word", ic_word, PAT);
        $display("test fetch done");
    endtask

    initial begin
        core_byte_order_bit = 1'b1;
        {dc_req, dc_we, dc_mmio, ic_valid} = 4'h0;
        dc_size = EBLS_SZ_WORD;
        {dc_addr, dc_wdata, hwy_rdata, ic_lane_data} = '0;
        mem_base   = WIN;
        mem_limit  = WIN + 32'h1000;
        mmio_rdata = 32'ha1b2_c3d4;
        mem_rdata  = PAT;
        repeat (8) @(posedge core_clk);
        reset <= 1'b0;
        t_bridge();
        t_store();
        t_window();
        t_roundtrip();
        t_ifetch();
        complete_run();
    end

    initial begin
        #2000000;
        fail_count++;
        complete_run();
    end
endmodule
`default_nettype wire
